// >>> hw/usb_phy_side_control_bank.sv
// AHB-Lite register bank steering the USB PHY side controls and event status.
// Operation
// - Bits 12 and 11 switch on OTG minus and plus voltage sources, reset off.
// - Bit 10 enables the OTG minus line pull-down.
// - Bit 9 enables the OTG data-line source current.
// - Bits 8 and 7 enable OTG minus and plus sink currents.
// - Common-on zero keeps the 480MHz PLL clock running always.
// - Common-on one stops the clock only while both ports are suspended.
// - After a stop, wait 1ms of settling before the clock counts as usable.
// - Bit 10 selects controller or register VBUS drive toward the PHY.
// - Bit 11 holds the register VBUS drive value, reset zero.
// - Bits 9..6 drive OTG full-speed SE0, data, enable and owner, reset zero.
// - Bit 5 drives host ID pull-up, reset zero.
// - Bits 4 and 3 enable host minus and plus pull-downs, reset one.
// - Bits 2 and 1 drive host VBUS discharge and charge, reset zero.
// - Bit 0 drives host VBUS drive, reset one.
// - Bits 9:8 enable host disconnect rising and falling edges.
// - Bits 7:6 enable OTG disconnect rising and falling edges.
// - Bits 5:4 enable OTG ID rising and falling edges.
// - Bits 3:2 enable OTG B-valid rising and falling edges.
// - Bits 1 and 0 enable host and OTG line-state change status.
// - Enabled edges latch own status; clear pattern 01 or 10 clears one.
// - Writing one clears line-change status; zero does nothing.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module usb_phy_side_control_bank
  import usb_phy_side_pkg::*;
#(
  parameter int SETTLE_CYCLES = usb_phy_side_pkg::SETTLE_CYCLES_DEF,
  parameter int CNT_W = usb_phy_side_pkg::SETTLE_CNT_W
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // OTG charger detection controls
  output logic otg_dm_volt_src,
  output logic otg_dp_volt_src,
  output logic otg_dm_pull_down,
  output logic otg_dp_src_current,
  output logic otg_dm_sink_current,
  output logic otg_dp_sink_current,
  output logic [3:0] otg_bypass_ctrl,
  // PLL clock suspend control
  input wire logic otg_suspend,
  input wire logic host_suspend,
  output logic pll_clk_enable,
  output logic pll_clk_ready,
  // VBUS and line overrides
  input wire logic otg_ctrl_vbus_drive,
  output logic phy_otg_vbus_drive,
  output logic otg_fullspeed_single_ended_zero,
  output logic otg_fullspeed_line_data,
  output logic otg_fullspeed_output_enable,
  output logic otg_fullspeed_transceiver_owner,
  output logic host_id_pull_up,
  output logic host_dm_pull_down,
  output logic host_dp_pull_down,
  output logic host_vbus_discharge,
  output logic host_vbus_charge,
  output logic host_vbus_drive,
  // PHY event sources
  input wire logic host_disconnect,
  input wire logic otg_disconnect,
  input wire logic otg_id,
  input wire logic otg_bvalid,
  input wire logic [1:0] host_linestate,
  input wire logic [1:0] otg_linestate
);
  import usb_phy_side_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] masked_write(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [15:0] writable);
    logic [15:0] wren;
    wren = data[31:WREN_LSB] & writable;
    return (old & ~wren) | (data[15:0] & wren);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  bus_state_e bus_state, next_bus_state;
  logic [11:0] bus_addr, next_bus_addr;
  logic [31:0] next_hrdata;
  logic [15:0] charger_detect_and_clock_control, next_charger;
  logic [15:0] vbus_and_line_override_control, next_vbus_line;
  logic [15:0] phy_event_edge_enable, next_edge_enable;
  logic [9:0] event_status, next_event_status;
  logic [3:0] level_prev, next_level_prev;
  logic [1:0] host_line_prev, next_host_line_prev;
  logic [1:0] otg_line_prev, next_otg_line_prev;
  clk_state_e clk_state, next_clk_state;
  logic [CNT_W-1:0] settle_cnt, next_settle_cnt;
  logic addr_ok;
  logic write_now;
  logic [9:0] event_set;
  logic [9:0] event_clr;
  logic [3:0] level_now;
  logic both_suspended;
  logic common_on;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // Reads take one wait state so hrdata comes from a flop and sees a
  // write committed in the cycle just before.
  assign addr_ok = hsel && htrans[1] && hready;
  assign write_now = (bus_state == BUS_WRITE);
  assign hreadyout = (bus_state != BUS_READ);
  assign hresp = 1'b0;

  always_comb
  begin
    next_bus_state = BUS_IDLE;
    next_bus_addr = bus_addr;
    next_hrdata = hrdata;
    case (bus_state)
      BUS_READ:
      begin
        next_bus_state = BUS_READ_DONE;
        if (bus_addr == CHARGER_CLOCK_OFF)
          next_hrdata = {16'h0000, charger_detect_and_clock_control};
        else if (bus_addr == VBUS_LINE_OFF)
          next_hrdata = {16'h0000, vbus_and_line_override_control};
        else if (bus_addr == EDGE_ENABLE_OFF)
          next_hrdata = {16'h0000, phy_event_edge_enable};
        else if (bus_addr == EVENT_STATUS_OFF)
          next_hrdata = {22'h000000, event_status};
        else
          next_hrdata = 32'h00000000;
      end
      default:
      begin
        if (addr_ok)
        begin
          next_bus_state = hwrite ? BUS_WRITE : BUS_READ;
          next_bus_addr = haddr[11:0];
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_state <= BUS_IDLE;
      bus_addr <= 12'h000;
      hrdata <= 32'h00000000;
    end
    else
    begin
      bus_state <= next_bus_state;
      bus_addr <= next_bus_addr;
      hrdata <= next_hrdata;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_comb
  begin
    next_charger = charger_detect_and_clock_control;
    next_vbus_line = vbus_and_line_override_control;
    next_edge_enable = phy_event_edge_enable;
    if (write_now && bus_addr == CHARGER_CLOCK_OFF)
      next_charger = masked_write(charger_detect_and_clock_control, hwdata,
                                  CHARGER_CLOCK_WRITABLE);
    else if (write_now && bus_addr == VBUS_LINE_OFF)
      next_vbus_line = masked_write(vbus_and_line_override_control, hwdata,
                                    VBUS_LINE_WRITABLE);
    else if (write_now && bus_addr == EDGE_ENABLE_OFF)
      next_edge_enable = masked_write(phy_event_edge_enable, hwdata,
                                      EDGE_ENABLE_WRITABLE);
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      charger_detect_and_clock_control <= CHARGER_CLOCK_RST;
      vbus_and_line_override_control <= VBUS_LINE_RST;
      phy_event_edge_enable <= EDGE_ENABLE_RST;
    end
    else
    begin
      charger_detect_and_clock_control <= next_charger;
      vbus_and_line_override_control <= next_vbus_line;
      phy_event_edge_enable <= next_edge_enable;
    end
  end

  assign otg_dm_volt_src = charger_detect_and_clock_control[DM_VOLT_SRC_BIT];
  assign otg_dp_volt_src = charger_detect_and_clock_control[DP_VOLT_SRC_BIT];
  assign otg_dm_pull_down = charger_detect_and_clock_control[DM_PULL_DOWN_BIT];
  assign otg_dp_src_current = charger_detect_and_clock_control[DP_SRC_CURRENT_BIT];
  assign otg_dm_sink_current = charger_detect_and_clock_control[DM_SINK_BIT];
  assign otg_dp_sink_current = charger_detect_and_clock_control[DP_SINK_BIT];
  assign otg_bypass_ctrl = charger_detect_and_clock_control[BYPASS_MSB:0];
  assign common_on = charger_detect_and_clock_control[COMMON_ON_BIT];

  // Only the select path is combinational; the register value is held, but the controller input passes straight through.
  assign phy_otg_vbus_drive = vbus_and_line_override_control[OTG_VBUS_SEL_BIT] ?
    vbus_and_line_override_control[OTG_VBUS_VALUE_BIT] :
    otg_ctrl_vbus_drive;
  assign otg_fullspeed_single_ended_zero = vbus_and_line_override_control[FS_SE0_BIT];
  assign otg_fullspeed_line_data = vbus_and_line_override_control[FS_DATA_BIT];
  assign otg_fullspeed_output_enable = vbus_and_line_override_control[FS_OE_BIT];
  assign otg_fullspeed_transceiver_owner =
    vbus_and_line_override_control[FS_OWNER_BIT];
  assign host_id_pull_up = vbus_and_line_override_control[HOST_ID_PULL_UP_BIT];
  assign host_dm_pull_down = vbus_and_line_override_control[HOST_DM_PULL_DOWN_BIT];
  assign host_dp_pull_down = vbus_and_line_override_control[HOST_DP_PULL_DOWN_BIT];
  assign host_vbus_discharge = vbus_and_line_override_control[HOST_DISCHARGE_BIT];
  assign host_vbus_charge = vbus_and_line_override_control[HOST_CHARGE_BIT];
  assign host_vbus_drive = vbus_and_line_override_control[HOST_VBUS_DRIVE_BIT];

  mask_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    write_now && bus_addr == VBUS_LINE_OFF && !hwdata[WREN_LSB + HOST_VBUS_DRIVE_BIT]
    |=> $stable(host_vbus_drive))
    else $error("host VBUS drive changed without its write enable");

  vbus_select_a: assert property (@(posedge mclk) disable iff (!nrst)
    write_now && bus_addr == VBUS_LINE_OFF && hwdata[27:26] == 2'b11 && hwdata[11:10] == 2'b01
    |=> phy_otg_vbus_drive == 1'b0)
    else $error("register VBUS value not routed to the PHY");

  // ****************************************************************
  // PLL clock suspend control
  // ****************************************************************
  // The settle wait runs on this clock, so mclk must not come from the
  // gated 480MHz output.
  assign both_suspended = otg_suspend && host_suspend;

  always_comb
  begin
    next_clk_state = clk_state;
    next_settle_cnt = settle_cnt;
    case (clk_state)
      CLK_RUN:
      begin
        if (common_on && both_suspended)
          next_clk_state = CLK_STOPPED;
      end
      CLK_STOPPED:
      begin
        if (!(common_on && both_suspended))
        begin
          next_clk_state = CLK_SETTLE;
          next_settle_cnt = '0;
        end
      end
      CLK_SETTLE:
      begin
        if (common_on && both_suspended)
          next_clk_state = CLK_STOPPED;
        else if (settle_cnt == CNT_W'(SETTLE_CYCLES - 1))
          next_clk_state = CLK_RUN;
        else
          next_settle_cnt = settle_cnt + 1'b1;
      end
      default:
      begin
        next_clk_state = CLK_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      clk_state <= CLK_RUN;
      settle_cnt <= '0;
    end
    else
    begin
      clk_state <= next_clk_state;
      settle_cnt <= next_settle_cnt;
    end
  end

  assign pll_clk_enable = (clk_state != CLK_STOPPED);
  assign pll_clk_ready = (clk_state == CLK_RUN);

  clock_on_a: assert property (@(posedge mclk) disable iff (!nrst)
    !common_on && $past(!common_on) |-> pll_clk_enable)
    else $error("PLL clock stopped with common-on clear");

  clock_stop_a: assert property (@(posedge mclk) disable iff (!nrst)
    !pll_clk_enable |-> $past(common_on && otg_suspend && host_suspend))
    else $error("PLL clock stopped without both ports suspended");

  stop_entry_a: assert property (@(posedge mclk) disable iff (!nrst)
    clk_state == CLK_RUN && common_on && otg_suspend && host_suspend |=> !pll_clk_enable)
    else $error("PLL clock kept running in full suspend");

  settle_wait_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(pll_clk_ready) |-> $past(settle_cnt) == CNT_W'(SETTLE_CYCLES - 1)
    && $past(clk_state) == CLK_SETTLE)
    else $error("PLL clock marked usable before the settle time");

  // ****************************************************************
  // Event detection and status
  // ****************************************************************
  // Edge history resets low, so an input already high at release shows
  // as a rising edge if that edge is enabled at once.
  assign level_now = {host_disconnect, otg_disconnect, otg_id, otg_bvalid};

  always_comb
  begin
    event_set = 10'h000;
    event_clr = 10'h000;
    for (int i = 0; i < EDGE_PAIRS; i++)
    begin
      event_set[2*i+2] = phy_event_edge_enable[2*i+2] && level_now[i] && !level_prev[i];
      event_set[2*i+3] = phy_event_edge_enable[2*i+3] && !level_now[i] && level_prev[i];
      if (write_now && bus_addr == EVENT_CLEAR_OFF)
      begin
        event_clr[2*i+2] = (hwdata[2*i+3 -: 2] == 2'b01);
        event_clr[2*i+3] = (hwdata[2*i+3 -: 2] == 2'b10);
      end
    end
    event_set[HOST_LINE_BIT] = phy_event_edge_enable[HOST_LINE_BIT]
      && (host_linestate != host_line_prev);
    event_set[OTG_LINE_BIT] = phy_event_edge_enable[OTG_LINE_BIT]
      && (otg_linestate != otg_line_prev);
    if (write_now && bus_addr == EVENT_CLEAR_OFF)
    begin
      event_clr[HOST_LINE_BIT] = hwdata[HOST_LINE_BIT];
      event_clr[OTG_LINE_BIT] = hwdata[OTG_LINE_BIT];
    end
    // A new event in the clearing cycle survives the clear.
    next_event_status = (event_status & ~(event_clr & EVENT_CLEAR_USED)) | event_set;
    next_level_prev = level_now;
    next_host_line_prev = host_linestate;
    next_otg_line_prev = otg_linestate;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      event_status <= EVENT_STATUS_RST;
      level_prev <= 4'h0;
      host_line_prev <= 2'h0;
      otg_line_prev <= 2'h0;
    end
    else
    begin
      event_status <= next_event_status;
      level_prev <= next_level_prev;
      host_line_prev <= next_host_line_prev;
      otg_line_prev <= next_otg_line_prev;
    end
  end

  host_unplug_rise_a: assert property (@(posedge mclk) disable iff (!nrst)
    phy_event_edge_enable[8] && $rose(host_disconnect) |=> event_status[8])
    else $error("host disconnect rising edge not latched");

  id_fall_a: assert property (@(posedge mclk) disable iff (!nrst)
    !phy_event_edge_enable[5] && $fell(otg_id) && !$past(event_status[5])
    |=> !event_status[5])
    else $error("disabled ID falling edge was latched");

  edge_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    write_now && bus_addr == EVENT_CLEAR_OFF && hwdata[3:2] == 2'b01 && !event_set[2]
    |=> !event_status[2] && event_status[3] == $past(event_status[3] || event_set[3]))
    else $error("B-valid edge clear hit the wrong bit");

  line_change_a: assert property (@(posedge mclk) disable iff (!nrst)
    phy_event_edge_enable[0] && otg_linestate != $past(otg_linestate) |-> ##1 event_status[0])
    else $error("OTG line-state change not latched");

  line_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    write_now && bus_addr == EVENT_CLEAR_OFF && !hwdata[1] && event_status[1]
    |=> event_status[1])
    else $error("host line-state status cleared by a zero");

endmodule

// >>> hw/usb_phy_side_pkg.sv
// Constants shared by the USB PHY side control register bank.
package usb_phy_side_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [11:0] CHARGER_CLOCK_OFF = 12'h108;
  localparam logic [11:0] VBUS_LINE_OFF = 12'h10C;
  localparam logic [11:0] EDGE_ENABLE_OFF = 12'h110;
  localparam logic [11:0] EVENT_STATUS_OFF = 12'h114;
  localparam logic [11:0] EVENT_CLEAR_OFF = 12'h118;

  // ****************************************************************
  // Write-enable half and writable bits
  // ****************************************************************
  localparam int WREN_LSB = 16;
  localparam logic [15:0] CHARGER_CLOCK_WRITABLE = 16'h1F9F;
  localparam logic [15:0] VBUS_LINE_WRITABLE = 16'h0FFF;
  localparam logic [15:0] EDGE_ENABLE_WRITABLE = 16'h03FF;
  localparam logic [9:0] EVENT_CLEAR_USED = 10'h3FF;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] CHARGER_CLOCK_RST = 16'h0000;
  localparam logic [15:0] VBUS_LINE_RST = 16'h0019;
  localparam logic [15:0] EDGE_ENABLE_RST = 16'h0000;
  localparam logic [9:0] EVENT_STATUS_RST = 10'h000;

  // ****************************************************************
  // Charger detection and clock control fields
  // ****************************************************************
  localparam int DM_VOLT_SRC_BIT = 12;
  localparam int DP_VOLT_SRC_BIT = 11;
  localparam int DM_PULL_DOWN_BIT = 10;
  localparam int DP_SRC_CURRENT_BIT = 9;
  localparam int DM_SINK_BIT = 8;
  localparam int DP_SINK_BIT = 7;
  localparam int COMMON_ON_BIT = 4;
  localparam int BYPASS_MSB = 3;

  // ****************************************************************
  // VBUS and line override fields
  // ****************************************************************
  localparam int OTG_VBUS_VALUE_BIT = 11;
  localparam int OTG_VBUS_SEL_BIT = 10;
  localparam int FS_SE0_BIT = 9;
  localparam int FS_DATA_BIT = 8;
  localparam int FS_OE_BIT = 7;
  localparam int FS_OWNER_BIT = 6;
  localparam int HOST_ID_PULL_UP_BIT = 5;
  localparam int HOST_DM_PULL_DOWN_BIT = 4;
  localparam int HOST_DP_PULL_DOWN_BIT = 3;
  localparam int HOST_DISCHARGE_BIT = 2;
  localparam int HOST_CHARGE_BIT = 1;
  localparam int HOST_VBUS_DRIVE_BIT = 0;

  // ****************************************************************
  // Event fields: edge pair n sits at bits 2n+3:2n+2
  // ****************************************************************
  localparam int EDGE_PAIRS = 4;
  localparam int HOST_LINE_BIT = 1;
  localparam int OTG_LINE_BIT = 0;

  // ****************************************************************
  // Clock settling
  // ****************************************************************
  localparam int CLK_FREQ_MHZ = 20;
  localparam int SETTLE_TIME_US = 1000;
  localparam int SETTLE_CYCLES_DEF = SETTLE_TIME_US * CLK_FREQ_MHZ;
  localparam int SETTLE_CNT_W = 15;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10,
    BUS_READ_DONE = 2'b11
  } bus_state_e;

  typedef enum logic [1:0] {
    CLK_RUN = 2'b00,
    CLK_STOPPED = 2'b01,
    CLK_SETTLE = 2'b10
  } clk_state_e;
endpackage

// >>> verif/phy_partner.sv
// Behavioural model of the PHY and USB controllers around the bank.
`timescale 1ns/1ps
module phy_partner
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Levels requested by the bench
  input wire logic [10:0] want,
  // Levels toward the bank
  output logic otg_ctrl_vbus_drive,
  output logic host_suspend,
  output logic otg_suspend,
  output logic host_disconnect,
  output logic otg_disconnect,
  output logic otg_id,
  output logic otg_bvalid,
  output logic [1:0] host_linestate,
  output logic [1:0] otg_linestate
);
  logic [10:0] lvl;
  // The PHY side is synchronous to mclk, so levels only move on the rising edge
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      lvl <= 11'h000;
    else
      lvl <= want;
  end
  assign {otg_ctrl_vbus_drive, host_suspend, otg_suspend, host_disconnect, otg_disconnect,
    otg_id, otg_bvalid, host_linestate, otg_linestate} = lvl;
endmodule

// >>> verif/tb.sv
// Self-checking bench for the USB PHY side control register bank.
`timescale 1ns/1ps
module tb;
  import usb_phy_side_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [10:0] want = 11'h000;
  logic hreadyout, hresp, pll_clk_enable, pll_clk_ready, phy_otg_vbus_drive;
  logic otg_dm_volt_src, otg_dp_volt_src, otg_dm_pull_down, otg_dp_src_current;
  logic otg_dm_sink_current, otg_dp_sink_current, host_id_pull_up, host_dm_pull_down;
  logic otg_fullspeed_single_ended_zero, otg_fullspeed_line_data;
  logic otg_fullspeed_output_enable, otg_fullspeed_transceiver_owner;
  logic host_dp_pull_down, host_vbus_discharge, host_vbus_charge, host_vbus_drive;
  logic otg_ctrl_vbus_drive, host_suspend, otg_suspend, host_disconnect, otg_disconnect;
  logic otg_id, otg_bvalid;
  logic [1:0] host_linestate, otg_linestate;
  logic [3:0] otg_bypass_ctrl;
  logic [31:0] hrdata;
  logic [15:0] m[3];
  logic [15:0] wm[3] = '{CHARGER_CLOCK_WRITABLE, VBUS_LINE_WRITABLE, EDGE_ENABLE_WRITABLE};
  logic [11:0] off[3] = '{CHARGER_CLOCK_OFF, VBUS_LINE_OFF, EDGE_ENABLE_OFF};
  logic [31:0] q[$];
  logic [15:0] r = 16'hF110;
  logic [15:0] en;
  logic rd_wait = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  int n;
  localparam int SETTLE_TB = 8;
  always #25 mclk = ~mclk;
  // A short settle count keeps the clock-restart scenario brief
  usb_phy_side_control_bank #(.SETTLE_CYCLES(SETTLE_TB)) i_dut (.mclk, .nrst, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .otg_dm_volt_src, .otg_dp_volt_src, .otg_dm_pull_down, .otg_dp_src_current,
    .otg_dm_sink_current, .otg_dp_sink_current, .otg_bypass_ctrl, .otg_suspend, .host_suspend,
    .pll_clk_enable, .pll_clk_ready, .otg_ctrl_vbus_drive, .phy_otg_vbus_drive,
    .otg_fullspeed_single_ended_zero, .otg_fullspeed_line_data, .otg_fullspeed_output_enable,
    .otg_fullspeed_transceiver_owner, .host_id_pull_up, .host_dm_pull_down, .host_dp_pull_down,
    .host_vbus_discharge, .host_vbus_charge, .host_vbus_drive, .host_disconnect,
    .otg_disconnect, .otg_id, .otg_bvalid, .host_linestate, .otg_linestate);
  phy_partner i_phy (.mclk, .nrst, .want, .otg_ctrl_vbus_drive, .host_suspend, .otg_suspend,
    .host_disconnect, .otg_disconnect, .otg_id, .otg_bvalid, .host_linestate, .otg_linestate);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    // A read note never matched means a read answer went missing
    if (q.size() != 0)
    begin
      err_count++;
      $display("BAD read_queue expected 0 seen %0d", q.size());
    end
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One single AHB-Lite transfer; wait states are bounded
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k = 0;
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && k < 50)
    begin
      @(posedge mclk);
      k++;
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && k < 50)
    begin
      @(posedge mclk);
      k++;
    end
    if (k >= 50)
    begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic wr(input int i, input logic [15:0] e, input logic [15:0] d);
    bus(off[i], 1'b1, {e, d});
    m[i] = (m[i] & ~(e & wm[i])) | (d & e & wm[i]);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic pins();
    cmp("chg", 32'({m[0][12:7], m[0][3:0]}), 32'({otg_dm_volt_src, otg_dp_volt_src,
      otg_dm_pull_down, otg_dp_src_current, otg_dm_sink_current, otg_dp_sink_current,
      otg_bypass_ctrl}));
    cmp("line", 32'(m[1][9:0]), 32'({otg_fullspeed_single_ended_zero, otg_fullspeed_line_data,
      otg_fullspeed_output_enable, otg_fullspeed_transceiver_owner, host_id_pull_up,
      host_dm_pull_down, host_dp_pull_down, host_vbus_discharge, host_vbus_charge,
      host_vbus_drive}));
  endtask

  // Raise then drop every event source and move both line states away and back
  task automatic toggle();
    want <= {want[10:8], 8'hF5};
    repeat (4) @(posedge mclk);
    want <= {want[10:8], 8'h00};
    repeat (4) @(posedge mclk);
  endtask

  // Read data is judged where it appears, against the oldest note
  always @(posedge mclk)
  begin
    if (rd_wait && hreadyout === 1'b1)
    begin
      cmp("hrdata", q.pop_front(), hrdata);
      cmp("hresp", 32'h0, 32'(hresp));
      rd_wait <= 1'b0;
    end
    if (hsel && htrans[1] && hreadyout && !hwrite)
      rd_wait <= 1'b1;
  end

  initial
  begin
    m = '{16'h0000, 16'h0019, 16'h0000};
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 3; i++)
      rd(off[i], 32'(m[i]));
    pins();
    for (int k = 0; k < 12; k++)
    begin
      r = lfsr(r);
      en = r;
      r = lfsr(r);
      wr(k % 3, en, r);
      rd(off[k % 3], 32'(m[k % 3]));
      pins();
    end
    wr(0, 16'hFFFF, 16'h0000);
    want <= 11'h400;
    wr(1, 16'h0C00, 16'h0000);
    @(posedge mclk);
    cmp("vbus", 32'h1, 32'(phy_otg_vbus_drive));
    wr(1, 16'h0C00, 16'h0400);
    @(posedge mclk);
    cmp("vbus", 32'h0, 32'(phy_otg_vbus_drive));
    want <= 11'h000;
    wr(1, 16'h0800, 16'h0800);
    @(posedge mclk);
    cmp("vbus", 32'h1, 32'(phy_otg_vbus_drive));
    rd(12'h200, 32'h0);
    bus(EVENT_STATUS_OFF, 1'b1, 32'hFFFFFFFF);
    rd(EVENT_STATUS_OFF, 32'h0);
    wr(2, 16'hFFFF, 16'h03FF);
    toggle();
    rd(EVENT_STATUS_OFF, 32'h3FF);
    bus(EVENT_CLEAR_OFF, 1'b1, 32'h157);
    rd(EVENT_STATUS_OFF, 32'h2A8);
    bus(EVENT_CLEAR_OFF, 1'b1, 32'h3FC);
    rd(EVENT_STATUS_OFF, 32'h2A8);
    bus(EVENT_CLEAR_OFF, 1'b1, 32'h2A8);
    rd(EVENT_CLEAR_OFF, 32'h0);
    rd(EVENT_STATUS_OFF, 32'h0);
    wr(2, 16'hFFFF, 16'h0105);
    toggle();
    rd(EVENT_STATUS_OFF, 32'h105);
    want <= 11'h300;
    repeat (4) @(posedge mclk);
    cmp("pll_en", 32'h1, 32'(pll_clk_enable));
    wr(0, 16'h0010, 16'h0010);
    repeat (3) @(posedge mclk);
    cmp("pll_en", 32'h0, 32'(pll_clk_enable));
    cmp("pll_rdy", 32'h0, 32'(pll_clk_ready));
    want <= 11'h100;
    n = 0;
    while (pll_clk_ready !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    // Partner delay, leaving the stop and the sampling edge add three edges
    cmp("settle", 32'(SETTLE_TB + 3), 32'(n));
    cmp("pll_en", 32'h1, 32'(pll_clk_enable));
    end_sim();
  end
endmodule
